// *** rdc_counter.v ***
`default_nettype none
`include "rdc_regs.vh"

module rdc_counter #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             ref_clk_i,
    input  wire             srst_i,
    // Control
    input  wire             run_i,
    input  wire [1:0]       mode_i,
    input  wire             tick_i,
    // Register write
    input  wire             wr_i,
    input  wire [WIDTH-1:0] wdata_i,
    // Status
    output reg  [WIDTH-1:0] count_o,
    output reg  [WIDTH-1:0] reload_o,
    output reg              udf_o
);

    reg  started;
    wire counting = run_i && (mode_i != `RDC_MODE_MEASURE);
    wire active   = counting && tick_i;

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            count_o  <= `RDC_CNT_RESET;
            reload_o <= `RDC_CNT_RESET;
            udf_o    <= 1'b0;
            started  <= 1'b0;
        end else begin
            udf_o <= 1'b0;
            if (!run_i)
                started <= 1'b0;
            else if (active)
                started <= 1'b1;
            if (wr_i)
                reload_o <= wdata_i;
            if (active) begin
                if (count_o == {WIDTH{1'b0}}) begin
                    count_o <= wr_i ? wdata_i : reload_o;
                    udf_o   <= 1'b1;
                end else begin
                    count_o <= count_o - 1'b1;
                end
            end else if (wr_i && (!run_i || !started)) begin
                count_o <= wdata_i;
            end
        end
    end

endmodule // rdc_counter
`default_nettype wire

// *** rdc_evt_src.sv ***
`default_nettype none
module rdc_evt_src (
    // Clock and toggle requests
    input wire logic       ref_clk_i,
    input wire logic [5:0] pin_req_i,
    input wire logic [5:0] phase_req_i,
    // Event pins and phase clocks
    output wire logic [5:0] pin_o,
    output wire logic [5:0] phase_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels start low, one driver each
    logic [5:0] pin_lvl = 6'h00;
    logic [5:0] phase_lvl = 6'h00;
    assign pin_o = pin_lvl;
    assign phase_o = phase_lvl;
    always @(posedge ref_clk_i) begin
        pin_lvl <= pin_lvl ^ pin_req_i;
        phase_lvl <= phase_lvl ^ phase_req_i;
    end
endmodule // rdc_evt_src
`default_nettype wire

// *** rdc_regs.vh ***
`ifndef RDC_REGS_VH
`define RDC_REGS_VH

// Mode field encodings
`define RDC_MODE_TIMER      2'h0
`define RDC_MODE_EVENT      2'h1
`define RDC_MODE_MEASURE    2'h2
// Timer-mode count source select
`define RDC_SRC_F1          2'h0
`define RDC_SRC_F8          2'h1
`define RDC_SRC_F2N         2'h2
`define RDC_SRC_FC32        2'h3
// Event source select
`define RDC_EVT_PIN         2'h0
`define RDC_EVT_NEIGHBOUR   2'h1
`define RDC_EVT_PHASE       2'h2
// Pin edge select
`define RDC_EDGE_FALL       2'h0
`define RDC_EDGE_RISE       2'h1
`define RDC_EDGE_BOTH       2'h2
// Prescaler division ratios
`define RDC_F8_DIV          8
`define RDC_F2N_DIV         16
`define RDC_FC32_DIV        32
// Counter reset value and instance count
`define RDC_CNT_RESET       16'h0000
`define RDC_NUM_INST        6

`endif

// *** rdc_timer.v ***
// Function
// - Six identical counters, instances zero to five
// - Timer mode picks one of four sources
// - Decrement per event, reload on underflow
// - Underflow rate equals source over n+1
// - Run bit set starts counting in timer and event modes
// - Run bit cleared stops counting
// - Interrupt request on every underflow
// - Timer mode leaves input pin unused
// - Event mode pin is port or source
// - Counter read returns live count
// - Stopped or unstarted write loads both
// - Running write updates reload only
// - Pin edge falling, rising or both
// - Neighbour underflow source, with wraparound
// - Phase clock source for 1,2,4,5
// - Two-bit mode field per instance
// - All counters cleared to zero after reset; run flags not reset
`default_nettype none
`include "rdc_regs.vh"

module rdc_timer #(
    parameter WIDTH    = 16,
    parameter N_INST   = `RDC_NUM_INST,
    parameter F8_DIV   = `RDC_F8_DIV,
    parameter F2N_DIV  = `RDC_F2N_DIV,
    parameter FC32_DIV = `RDC_FC32_DIV
) (
    // Clock and reset
    input  wire                    ref_clk_i,
    input  wire                    srst_i,
    // Run flags, one per instance
    input  wire [N_INST-1:0]       run_flags_i,
    // Per-instance mode, source, event select and edge (2 bits each)
    input  wire [2*N_INST-1:0]     mode_i,
    input  wire [2*N_INST-1:0]     clk_sel_i,
    input  wire [2*N_INST-1:0]     evt_sel_i,
    input  wire [2*N_INST-1:0]     edge_sel_i,
    // Event pins and phase-shift clocks
    input  wire [N_INST-1:0]       event_input_pin_i,
    input  wire [N_INST-1:0]       phase_clk_i,
    // Counter register write
    input  wire [N_INST-1:0]       wr_i,
    input  wire [WIDTH-1:0]        wdata_i,
    // Status
    output wire [WIDTH*N_INST-1:0] count_o,
    output wire [WIDTH*N_INST-1:0] reload_o,
    output wire [N_INST-1:0]       irq_o,
    output wire [N_INST-1:0]       running_o
);

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: one-cycle enables for the divided sources
    localparam PW    = 8;
    localparam N_DIV = 3;

    localparam [PW-1:0] F8_LAST   = F8_DIV[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};
    localparam [PW-1:0] F2N_LAST  = F2N_DIV[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};
    localparam [PW-1:0] FC32_LAST = FC32_DIV[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};

    wire [N_DIV*PW-1:0] div_last = {FC32_LAST, F2N_LAST, F8_LAST};
    wire [N_DIV-1:0]    div_tick;
    wire                f8_tick   = div_tick[0];
    wire                f2n_tick  = div_tick[1];
    wire                fc32_tick = div_tick[2];

    // Each divider wraps on its own last count, so any ratio up to 256 works
    genvar d;
    generate
        for (d = 0; d < N_DIV; d = d + 1) begin : g_div
            reg [PW-1:0] cnt;

            assign div_tick[d] = (cnt == div_last[PW*d +: PW]);

            always @(posedge ref_clk_i) begin
                if (srst_i || div_tick[d]) begin
                    cnt <= {PW{1'b0}};
                end else begin
                    cnt <= cnt + {{(PW-1){1'b0}}, 1'b1};
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin and phase-clock edge history
    reg [N_INST-1:0] pin_q;
    reg [N_INST-1:0] ph_q;

    // History follows the pins through reset, so no false edge comes after it
    always @(posedge ref_clk_i) begin
        pin_q <= event_input_pin_i;
        ph_q  <= phase_clk_i;
    end

    wire [N_INST-1:0] udf;
    assign irq_o     = udf;
    assign running_o = run_flags_i;

    ////////////////////////////////////////////////////////////////////////
    // Instances
    genvar i;
    generate
        for (i = 0; i < N_INST; i = i + 1) begin : g_inst
            // Neighbour wraps within each group of three
            localparam NB = (i % 3 == 0) ? i + 2 : i - 1;
            localparam HAS_PH = (i % 3 != 0);
            wire [1:0] mode = mode_i[2*i+1:2*i];
            wire [1:0] csel = clk_sel_i[2*i+1:2*i];
            wire [1:0] esel = evt_sel_i[2*i+1:2*i];
            wire [1:0] edg  = edge_sel_i[2*i+1:2*i];
            wire rise = event_input_pin_i[i] & ~pin_q[i];
            wire fall = ~event_input_pin_i[i] & pin_q[i];
            reg  pin_ev;
            reg  tmr_ev;
            reg  evt_ev;
            reg  tick;

            // Counted edge of the event pin
            always @* begin
                case (edg)
                    `RDC_EDGE_FALL: pin_ev = fall;
                    `RDC_EDGE_RISE: pin_ev = rise;
                    `RDC_EDGE_BOTH: pin_ev = rise | fall;
                    default:        pin_ev = 1'b0;
                endcase
            end

            // Internal source for timer mode
            always @* begin
                case (csel)
                    `RDC_SRC_F1:   tmr_ev = 1'b1;
                    `RDC_SRC_F8:   tmr_ev = f8_tick;
                    `RDC_SRC_F2N:  tmr_ev = f2n_tick;
                    `RDC_SRC_FC32: tmr_ev = fc32_tick;
                    default:       tmr_ev = 1'b0;
                endcase
            end

            // Source for event counter mode
            always @* begin
                case (esel)
                    `RDC_EVT_PIN:       evt_ev = pin_ev;
                    `RDC_EVT_NEIGHBOUR: evt_ev = udf[NB];
                    `RDC_EVT_PHASE:     evt_ev = HAS_PH ? (phase_clk_i[i] & ~ph_q[i]) : 1'b0;
                    default:            evt_ev = 1'b0;
                endcase
            end

            // Timer mode never looks at the pin
            always @* begin
                case (mode)
                    `RDC_MODE_TIMER: tick = tmr_ev;
                    `RDC_MODE_EVENT: tick = evt_ev;
                    default:         tick = 1'b0;
                endcase
            end

            rdc_counter #(
                .WIDTH (WIDTH)
            ) u_cnt (
                .ref_clk_i (ref_clk_i),
                .srst_i    (srst_i),
                .run_i     (run_flags_i[i]),
                .mode_i    (mode),
                .tick_i    (tick),
                .wr_i      (wr_i[i]),
                .wdata_i   (wdata_i),
                .count_o   (count_o[WIDTH*i+WIDTH-1:WIDTH*i]),
                .reload_o  (reload_o[WIDTH*i+WIDTH-1:WIDTH*i]),
                .udf_o     (udf[i])
            );
        end
    endgenerate

endmodule // rdc_timer
`default_nettype wire

// *** rdc_timer_chk.sv ***
`default_nettype none
module rdc_timer_chk (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        srst_i,
    // Controls
    input wire logic [5:0]  run_flags_i,
    input wire logic [11:0] mode_i,
    input wire logic [11:0] clk_sel_i,
    input wire logic [5:0]  wr_i,
    input wire logic [15:0] wdata_i,
    // Status
    input wire logic [95:0] count_o,
    input wire logic [95:0] reload_o,
    input wire logic [5:0]  irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire [15:0] c0 = count_o[15:0];
    wire [15:0] r0 = reload_o[15:0];
    wire        f1 = run_flags_i[0] && mode_i[1:0] == 2'h0 && clk_sel_i[1:0] == 2'h0 && !wr_i[0];
    sequence s_f1_zero;
        f1 && c0 == 16'h0000;
    endsequence
    AST_DEC: assert property (f1 && c0 != 16'h0000 |=> c0 == $past(c0) - 16'h0001) else $error("no decrement");
    AST_RELOAD: assert property (s_f1_zero |=> irq_o[0] && c0 == $past(r0)) else $error("no reload");
    AST_IRQ_CAUSE: assert property (irq_o[0] |-> $past(c0) == 16'h0000 && $past(run_flags_i[0])) else $error("stray irq");
    AST_HOLD: assert property (!run_flags_i[0] && !wr_i[0] |=> $stable(c0) && !irq_o[0]) else $error("stopped moved");
    AST_WR_STOP: assert property (wr_i[0] && !run_flags_i[0] |=> c0 == $past(wdata_i) && r0 == $past(wdata_i)) else $error("load");
    AST_WR_RELOAD: assert property (wr_i[0] |=> r0 == $past(wdata_i)) else $error("reload write");
    AST_RELOAD_KEEP: assert property (!wr_i[0] |=> $stable(r0)) else $error("reload changed");
    AST_MEASURE: assert property (mode_i[1:0] == 2'h2 && !wr_i[0] |=> $stable(c0)) else $error("measure moved");
endmodule // rdc_timer_chk
bind rdc_timer rdc_timer_chk u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .run_flags_i(run_flags_i),
    .mode_i(mode_i), .clk_sel_i(clk_sel_i), .wr_i(wr_i), .wdata_i(wdata_i), .count_o(count_o),
    .reload_o(reload_o), .irq_o(irq_o));
`default_nettype wire

// *** tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, srst_i = 1;
    logic [5:0] run = 0, wr = 0, preq = 0, qreq = 0;
    logic [11:0] mode = 0, csel = 0, esel = 0, edg = 0;
    logic [15:0] wd = 0;
    wire [5:0] pin, phase, irq, runo;
    wire [95:0] cnt, rld;
    int fails = 0, total_checks = 0, n;
    rdc_timer uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .run_flags_i(run), .mode_i(mode), .clk_sel_i(csel),
        .evt_sel_i(esel), .edge_sel_i(edg), .event_input_pin_i(pin), .phase_clk_i(phase), .wr_i(wr),
        .wdata_i(wd), .count_o(cnt), .reload_o(rld), .irq_o(irq), .running_o(runo));
    rdc_evt_src u_src (.ref_clk_i(ref_clk_i), .pin_req_i(preq), .phase_req_i(qreq), .pin_o(pin), .phase_o(phase));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic put(input int i, input logic [15:0] d);
        @(negedge ref_clk_i);
        wr[i] = 1;
        wd = d;
        @(negedge ref_clk_i);
        wr[i] = 0;
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    initial begin
        #500us;
        fails++;
        stop_test();
    end
    initial begin
        repeat (8) @(negedge ref_clk_i);
        srst_i = 0;
        chk("count", 16'h0000, cnt[15:0]);
        mode[3:2] = 2'h1;
        esel[3:2] = 2'h1;
        put(1, 16'h00FF);
        run[1] = 1;
        chk("running", {10'h000, run}, {10'h000, runo});
        for (int s = 0; s < 4; s++) begin
            csel[1:0] = s[1:0];
            put(0, 16'h0001);
            chk("load", 16'h0001, cnt[15:0]);
            run[0] = 1;
            n = 0;
            repeat (128) begin
                @(posedge ref_clk_i);
                #1 n += irq[0];
            end
            chk("udf", 16'(64 >> (s == 0 ? 0 : s + 2)), 16'(n));
            @(negedge ref_clk_i);
            run[0] = 0;
        end
        repeat (3) @(negedge ref_clk_i);
        chk("chain", 16'h00B1, cnt[31:16]);
        csel[1:0] = 2'h0;
        put(0, 16'h0010);
        chk("load", 16'h0010, cnt[15:0]);
        run[0] = 1;
        put(0, 16'h0005);
        chk("reload", 16'h0005, rld[15:0]);
        chk("live", 16'h000E, cnt[15:0]);
        run[0] = 0;
        mode[1:0] = 2'h2;
        repeat (3) @(negedge ref_clk_i);
        run[0] = 1;
        repeat (5) @(negedge ref_clk_i);
        chk("hold", 16'h000E, cnt[15:0]);
        for (int e = 0; e < 3; e++) begin
            run[1] = 0;
            esel[3:2] = 2'h0;
            edg[3:2] = e[1:0];
            put(1, 16'h000A);
            run[1] = 1;
            preq[1] = 1;
            repeat (4) @(negedge ref_clk_i);
            preq[1] = 0;
            repeat (4) @(negedge ref_clk_i);
            chk("pin", 16'h000A - (e == 2 ? 16'h0004 : 16'h0002), cnt[31:16]);
        end
        run[1] = 0;
        preq[1] = 1;
        repeat (4) @(negedge ref_clk_i);
        preq[1] = 0;
        chk("stopped", 16'h0006, cnt[31:16]);
        mode[5:4] = 2'h1;
        esel[5:4] = 2'h2;
        put(2, 16'h000A);
        run[2] = 1;
        qreq[2] = 1;
        repeat (4) @(negedge ref_clk_i);
        qreq[2] = 0;
        repeat (4) @(negedge ref_clk_i);
        chk("phase", 16'h0008, cnt[47:32]);
        stop_test();
    end
endmodule // tb
`default_nettype wire
